/* File: hw/block_aux_adc_pkg.sv */
// constants, register map and state codes for the block/aux converter sequencer
// assumes a 250 MHz ref_clk and a word-wide AHB-Lite register port
package block_aux_adc_pkg;

    // clock and timing
    localparam int CLK_MHZ = 250;
    localparam int PROP_DELAY_NS = 10000;
    localparam int PROP_CYCLES = (PROP_DELAY_NS * CLK_MHZ) / 1000;
    localparam int PROP_W = 12;

    // register byte offsets
    localparam logic [7:0] OFS_MEASURE_CONTROL_REG = 8'h00;
    localparam logic [7:0] OFS_BLOCK_RESULT = 8'h04;
    localparam logic [7:0] OFS_THERM_CFG = 8'h08;
    localparam logic [7:0] OFS_AUX_CFG = 8'h0c;
    localparam logic [7:0] OFS_BAL_LIMIT = 8'h10;
    localparam logic [7:0] OFS_SCHED_STATUS = 8'h14;
    localparam logic [7:0] OFS_THERM_RESULT = 8'h20;
    localparam logic [7:0] OFS_AUX_RESULT = 8'h40;
    localparam logic [7:0] OFS_LAST = 8'h54;

    // measure_control_reg fields
    localparam int BIT_BLOCK_GO = 0;
    localparam int BIT_CELL_GO = 1;
    localparam int BIT_AUX_GO = 2;
    localparam int LEN_LSB = 4;
    localparam int LEN_W = 3;
    localparam logic [2:0] LEN_CODE_MAX = 3'h6;
    localparam logic [2:0] LEN_CODE_RESET = 3'h6;
    localparam logic [4:0] BITS_MIN = 5'h0a;
    localparam logic [4:0] BITS_FULL = 5'h10;
    localparam logic [4:0] AUX_BITS = 5'h0a;

    // aux_meas_config fields
    localparam int BIT_DIAG_SEL = 5;
    // bal limit fields
    localparam int OC_LSB = 0;
    localparam int UC_LSB = 8;
    localparam int LIMIT_W = 8;
    localparam int LIMIT_OUT_W = 10;

    // channel counts and converter channel codes
    localparam int N_THERM = 5;
    localparam int N_AUX = 6;
    localparam logic [3:0] CH_THERM0 = 4'h0;
    localparam logic [3:0] CH_MISC0 = 4'h5;
    localparam logic [3:0] CH_DIAG = 4'ha;
    localparam logic [3:0] CH_BLOCK = 4'hb;
    localparam int RESULT_W = 16;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [6:0] {
        ST_RR_GAP = 7'h01,
        ST_RR_PICK = 7'h02,
        ST_RR_CONV = 7'h04,
        ST_BLK_WAIT = 7'h08,
        ST_BLK_CONV = 7'h10,
        ST_AUX_PICK = 7'h20,
        ST_AUX_CONV = 7'h40
    } sched_state_t;

endpackage : block_aux_adc_pkg

/* File: hw/block_aux_adc_sequencer.sv */
// sequencer for the thirteenth converter: block, thermistor and manual aux measurements
// assumes the converter front end and cell converters run on ref_clk; registers on AHB-Lite
// Overview of operation
// - block_meas_go write starts block conversion after delay
// - while converting: go reads 1, result reads 0
// - block start aborts running rotation schedule immediately
// - rotation schedule restarts after block conversion ends
// - block and cell go together: convert simultaneously
// - 16-bit block result for cell-sum check
// - block result is always unsigned
// - short conversions left-aligned, low bits zero
// - thermistor inputs converted cyclically by rotation schedule
// - misc aux only on disabled thermistor channels
// - aux_meas_go runs only masked channels and diag
// - current limits: 8-bit, step 5V/2^10
`timescale 1ns/100ps
`default_nettype none

module block_aux_adc_sequencer
    import block_aux_adc_pkg::*;
#(
    parameter int RR_GAP_CYCLES = 1000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic adcDone,
    input wire logic [15:0] adcData,
    input wire logic cellDone,
    output logic adcStart,
    output logic adcAbort,
    output logic [3:0] adcChannel,
    output logic [4:0] adcBits,
    output logic cellStart,
    output logic rrActive,
    output logic [9:0] ocLimit,
    output logic [9:0] ucLimit
);
    localparam int GAP_W = 16;
    if (RR_GAP_CYCLES < 1 || RR_GAP_CYCLES > 65535) begin : g_bad_gap
        $error("RR_GAP_CYCLES out of range");
    end
    // bus state
    logic pend, next_pend, wrReg, next_wrReg, hitReg, next_hitReg, next_hreadyout;
    logic [7:0] addrReg, next_addrReg;
    logic [31:0] next_hrdata;
    // configuration
    logic [2:0] lenCode, next_lenCode;
    logic [4:0] thermEn, next_thermEn, auxMask, next_auxMask;
    logic [7:0] ocCode, next_ocCode, ucCode, next_ucCode;
    // scheduler
    sched_state_t state, next_state;
    logic diagSel, next_diagSel, blockGo, next_blockGo, cellGo, next_cellGo, auxGo, next_auxGo;
    logic cellWithBlock, next_cellWithBlock, next_adcStart, next_adcAbort, next_cellStart;
    logic next_rrActive, accept, wrStrobe, ctrlWrite, auxEligible, blockSet;
    logic [2:0] rrChan, next_rrChan, auxIdx, next_auxIdx;
    logic [GAP_W-1:0] gapCnt, next_gapCnt;
    logic [PROP_W-1:0] propCnt, next_propCnt;
    logic [15:0] blockResult, next_blockResult, blockMask, auxMaskBits;
    logic [15:0] thermResult [N_THERM], next_thermResult [N_THERM];
    logic [15:0] auxResult [N_AUX], next_auxResult [N_AUX];
    logic [3:0] next_adcChannel;
    logic [4:0] next_adcBits, blockBits;
    // left-aligned keep mask for a conversion of the given length
    function automatic logic [15:0] keep_mask(input logic [4:0] bits);
        return 16'hffff << (BITS_FULL - bits);
    endfunction : keep_mask
    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    // a software set wins over the hardware clear at conversion end
    assign blockSet = ctrlWrite && hwdata[BIT_BLOCK_GO]
                      && (!blockGo || (state == ST_BLK_CONV && adcDone));
    assign wrStrobe = pend && wrReg && hitReg;
    assign ctrlWrite = wrStrobe && (addrReg == OFS_MEASURE_CONTROL_REG);
    assign blockBits = BITS_MIN + {2'h0, (lenCode > LEN_CODE_MAX) ? LEN_CODE_MAX : lenCode};
    assign blockMask = keep_mask(blockBits);
    assign auxMaskBits = keep_mask(AUX_BITS);
    // misc channel only when its thermistor channel is off; last slot is diag
    assign auxEligible = (auxIdx < 3'h5) ? (auxMask[auxIdx] && !thermEn[auxIdx])
                                         : diagSel;
    // bus slave: one wait state, then registered read data
    always_comb begin
        logic [7:0] a;
        a = addrReg;
        next_pend = accept;
        next_wrReg = pend ? 1'b0 : wrReg;
        next_hitReg = hitReg;
        next_addrReg = addrReg;
        next_hreadyout = !accept;
        next_hrdata = hrdata;
        if (accept) begin
            next_wrReg = hwrite;
            next_addrReg = haddr[7:0];
            next_hitReg = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0)
                          && (hsize == HSIZE_WORD) && (haddr[7:0] <= OFS_LAST);
        end
        if (pend) begin
            next_hrdata = 32'h0;
            if (hitReg && !wrReg) begin
                if (a == OFS_MEASURE_CONTROL_REG) begin
                    next_hrdata[BIT_BLOCK_GO] = blockGo;
                    next_hrdata[BIT_CELL_GO] = cellGo;
                    next_hrdata[BIT_AUX_GO] = auxGo;
                    next_hrdata[LEN_LSB +: LEN_W] = lenCode;
                end else if (a == OFS_BLOCK_RESULT) begin
                    next_hrdata[15:0] = blockResult;
                end else if (a == OFS_THERM_CFG) begin
                    next_hrdata[4:0] = thermEn;
                end else if (a == OFS_AUX_CFG) begin
                    next_hrdata[4:0] = auxMask;
                    next_hrdata[BIT_DIAG_SEL] = diagSel;
                end else if (a == OFS_BAL_LIMIT) begin
                    next_hrdata[OC_LSB +: LIMIT_W] = ocCode;
                    next_hrdata[UC_LSB +: LIMIT_W] = ucCode;
                end else if (a == OFS_SCHED_STATUS) begin
                    next_hrdata[6:0] = state;
                    next_hrdata[10:8] = rrChan;
                end else if (a >= OFS_AUX_RESULT) begin
                    next_hrdata[15:0] = auxResult[3'((a - OFS_AUX_RESULT) >> 2)];
                end else if (a >= OFS_THERM_RESULT && a < OFS_THERM_RESULT + 8'h14) begin
                    next_hrdata[15:0] = thermResult[3'((a - OFS_THERM_RESULT) >> 2)];
                end
            end
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 1'b0;
            wrReg <= 1'b0;
            hitReg <= 1'b0;
            addrReg <= 8'h0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            hresp <= 1'b0;
        end else begin
            pend <= next_pend;
            wrReg <= next_wrReg;
            hitReg <= next_hitReg;
            addrReg <= next_addrReg;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
        end
    end
    // configuration registers and limit outputs
    always_comb begin
        next_lenCode = lenCode;
        next_thermEn = thermEn;
        next_auxMask = auxMask;
        next_diagSel = diagSel;
        next_ocCode = ocCode;
        next_ucCode = ucCode;
        if (ctrlWrite) begin
            next_lenCode = hwdata[LEN_LSB +: LEN_W];
        end
        if (wrStrobe && addrReg == OFS_THERM_CFG) begin
            next_thermEn = hwdata[4:0];
        end
        if (wrStrobe && addrReg == OFS_AUX_CFG) begin
            next_auxMask = hwdata[4:0];
            next_diagSel = hwdata[BIT_DIAG_SEL];
        end
        if (wrStrobe && addrReg == OFS_BAL_LIMIT) begin
            next_ocCode = hwdata[OC_LSB +: LIMIT_W];
            next_ucCode = hwdata[UC_LSB +: LIMIT_W];
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lenCode <= LEN_CODE_RESET;
            thermEn <= 5'h0;
            auxMask <= 5'h0;
            diagSel <= 1'b0;
            ocCode <= 8'h0;
            ucCode <= 8'h0;
            ocLimit <= 10'h0;
            ucLimit <= 10'h0;
        end else begin
            lenCode <= next_lenCode;
            thermEn <= next_thermEn;
            auxMask <= next_auxMask;
            diagSel <= next_diagSel;
            ocCode <= next_ocCode;
            ucCode <= next_ucCode;
            ocLimit <= {2'h0, next_ocCode};
            ucLimit <= {2'h0, next_ucCode};
        end
    end
    // scheduler: rotation schedule, block pre-emption, manual aux runs
    always_comb begin
        next_state = state;
        next_blockGo = blockGo;
        next_cellGo = cellGo;
        next_auxGo = auxGo;
        next_cellWithBlock = cellWithBlock;
        next_rrChan = rrChan;
        next_auxIdx = auxIdx;
        next_gapCnt = gapCnt;
        next_propCnt = propCnt;
        next_blockResult = blockResult;
        next_thermResult = thermResult;
        next_auxResult = auxResult;
        next_adcStart = 1'b0;
        next_adcAbort = 1'b0;
        next_cellStart = 1'b0;
        next_adcChannel = adcChannel;
        next_adcBits = adcBits;
        if (cellDone) begin
            next_cellGo = 1'b0;
        end
        case (state)
            ST_RR_GAP, ST_RR_PICK: begin
                if (blockGo) begin
                    next_propCnt = PROP_W'(PROP_CYCLES - 1);
                    next_state = ST_BLK_WAIT;
                end else if (auxGo) begin
                    next_auxIdx = 3'h0;
                    next_state = ST_AUX_PICK;
                end else if (state == ST_RR_GAP && gapCnt == '0) begin
                    next_rrChan = 3'h0;
                    next_state = ST_RR_PICK;
                end else if (state == ST_RR_GAP) begin
                    next_gapCnt = gapCnt - 1'b1;
                end else if (rrChan == 3'(N_THERM)) begin
                    next_gapCnt = GAP_W'(RR_GAP_CYCLES - 1);
                    next_state = ST_RR_GAP;
                end else if (thermEn[rrChan]) begin
                    next_adcStart = 1'b1;
                    next_adcChannel = CH_THERM0 + {1'b0, rrChan};
                    next_adcBits = AUX_BITS;
                    next_state = ST_RR_CONV;
                end else begin
                    next_rrChan = rrChan + 1'b1;
                end
            end
            ST_RR_CONV: begin
                if (blockGo) begin
                    next_adcAbort = 1'b1;
                    next_propCnt = PROP_W'(PROP_CYCLES - 1);
                    next_state = ST_BLK_WAIT;
                end else if (adcDone) begin
                    next_thermResult[rrChan] = adcData & auxMaskBits;
                    next_rrChan = rrChan + 1'b1;
                    next_state = ST_RR_PICK;
                end
            end
            ST_BLK_WAIT: begin
                next_blockResult = 16'h0;
                if (propCnt == '0) begin
                    next_adcStart = 1'b1;
                    next_adcChannel = CH_BLOCK;
                    next_adcBits = blockBits;
                    next_cellStart = cellWithBlock;
                    next_cellWithBlock = 1'b0;
                    next_state = ST_BLK_CONV;
                end else begin
                    next_propCnt = propCnt - 1'b1;
                end
            end
            ST_BLK_CONV: begin
                if (adcDone) begin
                    next_blockResult = adcData & blockMask;
                    next_blockGo = 1'b0;
                    next_rrChan = 3'h0;
                    next_state = ST_RR_PICK;
                end
            end
            ST_AUX_PICK: begin
                if (auxIdx == 3'(N_AUX)) begin
                    next_auxGo = 1'b0;
                    next_state = ST_RR_PICK;
                end else if (auxEligible) begin
                    next_adcStart = 1'b1;
                    next_adcChannel = (auxIdx == 3'h5) ? CH_DIAG : CH_MISC0 + {1'b0, auxIdx};
                    next_adcBits = AUX_BITS;
                    next_state = ST_AUX_CONV;
                end else begin
                    next_auxIdx = auxIdx + 1'b1;
                end
            end
            ST_AUX_CONV: begin
                if (adcDone) begin
                    next_auxResult[auxIdx] = adcData & auxMaskBits;
                    next_auxIdx = auxIdx + 1'b1;
                    next_state = ST_AUX_PICK;
                end
            end
            default: begin
                next_state = ST_RR_PICK;
            end
        endcase
        // software sets go bits; a set beats a hardware clear in the same cycle
        if (ctrlWrite) begin
            if (blockSet) begin
                next_blockGo = 1'b1;
                next_cellWithBlock = hwdata[BIT_CELL_GO];
            end
            if (hwdata[BIT_CELL_GO]) begin
                next_cellGo = 1'b1;
                next_cellStart = next_cellStart || !blockSet;
            end
            if (hwdata[BIT_AUX_GO]) begin
                next_auxGo = 1'b1;
            end
        end
        next_rrActive = (next_state == ST_RR_PICK) || (next_state == ST_RR_CONV);
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RR_PICK;
            blockGo <= 1'b0;
            cellGo <= 1'b0;
            auxGo <= 1'b0;
            cellWithBlock <= 1'b0;
            rrChan <= 3'h0;
            auxIdx <= 3'h0;
            gapCnt <= '0;
            propCnt <= '0;
            blockResult <= 16'h0;
            for (int i = 0; i < N_THERM; i++) begin
                thermResult[i] <= 16'h0;
            end
            for (int i = 0; i < N_AUX; i++) begin
                auxResult[i] <= 16'h0;
            end
            adcStart <= 1'b0;
            adcAbort <= 1'b0;
            adcChannel <= 4'h0;
            adcBits <= 5'h0;
            cellStart <= 1'b0;
            rrActive <= 1'b1;
        end else begin
            state <= next_state;
            blockGo <= next_blockGo;
            cellGo <= next_cellGo;
            auxGo <= next_auxGo;
            cellWithBlock <= next_cellWithBlock;
            rrChan <= next_rrChan;
            auxIdx <= next_auxIdx;
            gapCnt <= next_gapCnt;
            propCnt <= next_propCnt;
            blockResult <= next_blockResult;
            thermResult <= next_thermResult;
            auxResult <= next_auxResult;
            adcStart <= next_adcStart;
            adcAbort <= next_adcAbort;
            adcChannel <= next_adcChannel;
            adcBits <= next_adcBits;
            cellStart <= next_cellStart;
            rrActive <= next_rrActive;
        end
    end
endmodule : block_aux_adc_sequencer

`default_nettype wire

/* File: testbench/adc_front_model.sv */
// behavioural converter front end and cell converters
// assumes starts and aborts arrive on ref_clk; latency set by the bench
`timescale 1ns/100ps
`default_nettype none

module adc_front_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic adcStart,
    input wire logic adcAbort,
    input wire logic cellStart,
    input wire logic [3:0] adcChannel,
    input wire logic [7:0] lat,
    output logic adcDone,
    output logic [15:0] adcData,
    output logic cellDone
);
    int cnt;
    int cellCnt;
    logic [3:0] chan;
    logic [15:0] lastVal;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            cellCnt <= 0;
            chan <= 4'h0;
            lastVal <= 16'h0000;
            adcDone <= 1'b0;
            adcData <= 16'hffff;
            cellDone <= 1'b0;
        end else begin
            adcDone <= 1'b0;
            cellDone <= 1'b0;
            adcData <= ~lastVal;
            if (adcStart) begin
                cnt <= int'(lat) + 1;
                chan <= adcChannel;
            end else if (adcAbort) begin
                cnt <= 0;
            end else if (cnt == 1) begin
                cnt <= 0;
                adcDone <= 1'b1;
                adcData <= 16'h37e9 ^ {chan, 12'h000};
                lastVal <= 16'h37e9 ^ {chan, 12'h000};
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            if (cellStart) begin
                cellCnt <= int'(lat) + 1;
            end else if (cellCnt == 1) begin
                cellCnt <= 0;
                cellDone <= 1'b1;
            end else if (cellCnt != 0) begin
                cellCnt <= cellCnt - 1;
            end
        end
    end
endmodule : adc_front_model

`default_nettype wire

/* File: testbench/block_aux_adc_sequencer_properties.sv */
// concurrent checks on the port behaviour of the block/aux converter sequencer
// assumes a single ref_clk domain; bound to the sequencer module below
`timescale 1ns/100ps
`default_nettype none

module block_aux_adc_sequencer_properties
    import block_aux_adc_pkg::*;
#(
    parameter int RR_GAP_CYCLES = 1000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic adcDone,
    input wire logic [15:0] adcData,
    input wire logic cellDone,
    input wire logic adcStart,
    input wire logic adcAbort,
    input wire logic [3:0] adcChannel,
    input wire logic [4:0] adcBits,
    input wire logic cellStart,
    input wire logic rrActive,
    input wire logic [9:0] ocLimit,
    input wire logic [9:0] ucLimit
);
    logic wrPend, next_wrPend, convBusy, next_convBusy;
    logic blkConv, next_blkConv, cellWith, next_cellWith;
    logic [7:0] wrAddr, next_wrAddr;
    logic [4:0] thermShadow, next_thermShadow, expBits;
    logic [2:0] lenShadow, next_lenShadow;
    int blkCnt, next_blkCnt;
    logic blockReq, blkStart, limWr;

    assign blockReq = wrPend && wrAddr == OFS_MEASURE_CONTROL_REG && hwdata[BIT_BLOCK_GO];
    assign blkStart = adcStart && adcChannel == CH_BLOCK;
    assign limWr = wrPend && wrAddr == OFS_BAL_LIMIT;
    assign expBits = (lenShadow > LEN_CODE_MAX) ? BITS_FULL : BITS_MIN + 5'(lenShadow);

    always_comb begin
        next_wrPend = hsel && hready && htrans == HTRANS_NONSEQ && hwrite
            && hsize == HSIZE_WORD && haddr[31:8] == 24'h0;
        next_wrAddr = haddr[7:0];
        next_thermShadow = (wrPend && wrAddr == OFS_THERM_CFG) ? hwdata[4:0] : thermShadow;
        next_lenShadow = (wrPend && wrAddr == OFS_MEASURE_CONTROL_REG) ? hwdata[LEN_LSB +: LEN_W] : lenShadow;
        next_convBusy = adcStart || (convBusy && !adcDone && !adcAbort);
        next_blkConv = blkStart || (blkConv && !adcDone);
        next_cellWith = (blockReq && hwdata[BIT_CELL_GO]) || (cellWith && !blkStart);
        next_blkCnt = blkStart ? 0 : (blkCnt != 0) ? blkCnt + 1 : (blockReq ? 1 : 0);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            thermShadow <= 5'h00;
            lenShadow <= LEN_CODE_RESET;
            convBusy <= 1'b0;
            blkConv <= 1'b0;
            cellWith <= 1'b0;
            blkCnt <= 0;
        end else begin
            wrPend <= next_wrPend;
            wrAddr <= next_wrAddr;
            thermShadow <= next_thermShadow;
            lenShadow <= next_lenShadow;
            convBusy <= next_convBusy;
            blkConv <= next_blkConv;
            cellWith <= next_cellWith;
            blkCnt <= next_blkCnt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_block_launch;
        adcStart && adcChannel == CH_BLOCK;
    endsequence
    sequence s_addr_taken;
        hsel && hready && htrans == HTRANS_NONSEQ;
    endsequence

    a_block_delay: assert property (s_block_launch |-> blkCnt >= PROP_CYCLES - 2)
        else $error("block conversion started before the propagation delay");
    a_block_bound: assert property (blkCnt < PROP_CYCLES + 1000)
        else $error("block conversion never started");
    a_block_bits: assert property (s_block_launch |-> adcBits == expBits)
        else $error("block conversion length differs from length code");
    a_cell_together: assert property (blkStart && cellWith |-> cellStart)
        else $error("cell conversion not started with block conversion");
    a_abort_rotation: assert property (
        blockReq && convBusy && !adcDone && adcChannel < CH_MISC0 |-> ##[0:3] adcAbort)
        else $error("running rotation conversion not aborted");
    a_rotation_held: assert property (
        blkCnt > 1 && blkCnt < PROP_CYCLES - 2 |-> !(adcStart && adcChannel < CH_MISC0))
        else $error("rotation conversion started while block pending");
    a_rotation_restart: assert property (blkConv && adcDone |-> ##[1:2] rrActive)
        else $error("rotation not restarted after block conversion");
    a_misc_disabled: assert property (
        adcStart && adcChannel >= CH_MISC0 && adcChannel < CH_DIAG
        |-> !thermShadow[adcChannel - CH_MISC0])
        else $error("misc conversion on an enabled thermistor pin");
    a_therm_enabled: assert property (
        adcStart && adcChannel < CH_MISC0 |-> thermShadow[adcChannel[2:0]])
        else $error("rotation converted a disabled thermistor input");
    a_limit_map: assert property (limWr |-> ##2
        ocLimit == {2'h0, $past(hwdata[7:0], 2)} && ucLimit == {2'h0, $past(hwdata[15:8], 2)})
        else $error("current limit outputs differ from written codes");
    a_ready_gap: assert property (s_addr_taken |=> !hreadyout && !hresp ##1 hreadyout)
        else $error("bus data phase not two cycles with okay response");
endmodule : block_aux_adc_sequencer_properties

bind block_aux_adc_sequencer block_aux_adc_sequencer_properties #(
    .RR_GAP_CYCLES(RR_GAP_CYCLES)
) u_props (.*);

`default_nettype wire

/* File: testbench/tb_block_aux_adc_sequencer.sv */
// self-checking bench: AHB-Lite register traffic against the sequencer and converter model
// assumes a 250 MHz ref_clk and a shortened rotation gap
`timescale 1ns/100ps
`default_nettype none

module tb_block_aux_adc_sequencer;
    import block_aux_adc_pkg::*;
    logic ref_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic adcDone, cellDone, adcStart, adcAbort, cellStart, rrActive;
    logic [15:0] adcData, expv;
    logic [3:0] adcChannel;
    logic [4:0] adcBits;
    logic [9:0] ocLimit, ucLimit;
    logic [7:0] lat;
    logic [15:0] auxExp [6] = '{16'h67c0, 16'h57c0, 16'h0000, 16'h0000, 16'h0000, 16'h97c0};
    int n_errors, comparisons, bits;

    assign hready = hreadyout;

    block_aux_adc_sequencer #(.RR_GAP_CYCLES(4)) uut (.*);
    adc_front_model model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                            output logic [31:0] rdv);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 80);
        rdv = hrdata;
        if (n >= 80) begin
            n_errors++;
            wrap_up();
        end
    endtask : bus_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus_xfer(1'b0, a, 32'h0, v);
        check(what, v, exp);
    endtask : rd_chk

    task automatic poll(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] want);
        logic [31:0] v;
        int n;
        n = 0;
        do begin
            bus_xfer(1'b0, a, 32'h0, v);
            n++;
        end while ((v & m) !== want && n < 1500);
        check(what, v & m, want);
    endtask : poll

    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        lat = 8'd20;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rd_chk("control reset", OFS_MEASURE_CONTROL_REG, 32'h0000_0060);
        rd_chk("block result reset", OFS_BLOCK_RESULT, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        rd_chk("unmapped", 8'h18, 32'h0);
        wr(OFS_BAL_LIMIT, 32'h0000_a5ff);
        rd_chk("limits", OFS_BAL_LIMIT, 32'h0000_a5ff);
        wr(OFS_THERM_CFG, 32'h1f);
        poll("thermistor 0 result", OFS_THERM_RESULT, 32'hffff, 32'h37c0);
        for (int c = 0; c < 8; c++) begin
            bits = (c > 6) ? 16 : 10 + c;
            lat <= c[0] ? 8'd3 : 8'd150;
            wr(OFS_MEASURE_CONTROL_REG, 32'h3 | 32'(c << 4));
            bus_xfer(1'b0, OFS_MEASURE_CONTROL_REG, 32'h0, rd);
            check("block go while busy", rd & 32'h1, 32'h1);
            rd_chk("result while busy", OFS_BLOCK_RESULT, 32'h0);
            poll("go bits cleared", OFS_MEASURE_CONTROL_REG, 32'h7, 32'h0);
            expv = 16'h87e9 & (16'hffff << (16 - bits));
            rd_chk("block result", OFS_BLOCK_RESULT, {16'h0, expv});
        end
        lat <= 8'd20;
        wr(OFS_THERM_CFG, 32'h1c);
        wr(OFS_AUX_CFG, 32'h27);
        wr(OFS_MEASURE_CONTROL_REG, 32'h64);
        poll("aux go cleared", OFS_MEASURE_CONTROL_REG, 32'h4, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd_chk("aux result", OFS_AUX_RESULT + 8'(4 * i), {16'h0, auxExp[i]});
        end
        wrap_up();
    end
endmodule : tb_block_aux_adc_sequencer

`default_nettype wire
